// *** core/adcseq_map.vh ***
`ifndef ADCSEQ_MAP_VH
`define ADCSEQ_MAP_VH
// APB byte offsets
`define ADCSEQ_CMD1_OFF 12'h000
`define ADCSEQ_CMD2_OFF 12'h004
`define ADCSEQ_STAT1_OFF 12'h008
`define ADCSEQ_STAT2_OFF 12'h00c
`define ADCSEQ_FIFO_LO_OFF 12'h010
`define ADCSEQ_FIFO_HI_OFF 12'h014
`define ADCSEQ_CLEAR_OFF 12'h018
`define ADCSEQ_TMR_BASE_OFF 12'h020
`define ADCSEQ_TMR_LAST_OFF 12'h02c
// Command 1 fields
`define ADCSEQ_CMD1_CH_LSB 0
`define ADCSEQ_CMD1_CH_MSB 2
`define ADCSEQ_CMD1_SCAN_N 3
`define ADCSEQ_CMD1_IRQEN 4
`define ADCSEQ_CMD1_RST 8'h08
// Command 2 fields
`define ADCSEQ_CMD2_ACQOFF 1
`define ADCSEQ_CMD2_RST 8'h02
// Status 1 fields
`define ADCSEQ_ST1_READY 0
`define ADCSEQ_ST1_ERR 1
`define ADCSEQ_ST1_BUSY 2
`define ADCSEQ_ST1_IRQ 3
// Status 2 fields
`define ADCSEQ_ST2_OVFL 0
`define ADCSEQ_ST2_OVRN 1
// FIFO geometry
`define ADCSEQ_FIFO_DEPTH 5'h10
`define ADCSEQ_FIFO_AW 4
`define ADCSEQ_DW 12
// Timing: 125 MHz core, 1 MHz reference
`define ADCSEQ_CLK_MHZ 125
`define ADCSEQ_REF_MHZ 1
`define ADCSEQ_REF_HALF (`ADCSEQ_CLK_MHZ / `ADCSEQ_REF_MHZ / 2)
`define ADCSEQ_REF_HALF_W 7
`endif

// *** core/adcseq_fifo_mem.v ***
`timescale 1ns/1ns
`include "adcseq_map.vh"
// Result storage, registered read port
module adcseq_fifo_mem (
  // Clock
  input wire pclk,
  // Write port
  input wire wr_en,
  input wire [`ADCSEQ_FIFO_AW-1:0] wr_addr,
  input wire [`ADCSEQ_DW-1:0] wr_data,
  // Read port
  input wire [`ADCSEQ_FIFO_AW-1:0] rd_addr,
  output reg [`ADCSEQ_DW-1:0] rd_data
);
  // Storage array, no reset needed for data
  reg [`ADCSEQ_DW-1:0] mem [0:`ADCSEQ_FIFO_DEPTH-1];

  // Write and registered read
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // adcseq_fifo_mem

// *** core/adcseq_top.v ***
`timescale 1ns/1ns
`include "adcseq_map.vh"
// How it works
// R1: Either error sets combined error flag
// R2: Full FIFO plus new result flags overflow
// R3: Trigger during busy conversion flags overrun, skipped
// R4: Clear write resets all three error flags
// R5: Host polls error flag with ready flag
// R6: scan_on_n low scans, high single channel
// R7: Scan descends from selected channel, wraps
// R8: Host writes command twice to start scan
// R9: Scan paced like single-channel acquisition
// R10: Interrupt follows ready flag when enabled
// R11: Interrupt holds until FIFO empty
// R12: Sample counter clocked by fixed 1 MHz reference
// R13: 1 MHz reference driven to connector
// R14: Counters 1 and 2 stay general purpose
// R15: Timer accesses are single byte wide
// R16: Counter output rising edge starts conversion
// R17: External edge counts only while counter output high
// R18: acquisition_off blocks both trigger sources
// R19: Ready at status bit 0; low then high byte
// R20: Full FIFO drops new result; high read pops
module adcseq_top (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Trigger sources
  input wire sample_counter_output,
  input wire external_convert_n,
  // Converter handshake
  output reg conv_start,
  output reg [2:0] conv_channel,
  input wire conv_done,
  input wire [`ADCSEQ_DW-1:0] conv_result,
  // Interval timer byte port and reference clock
  output reg ref_clk_1mhz,
  output reg tmr_cs,
  output reg tmr_wr,
  output reg [1:0] tmr_addr,
  output reg [7:0] tmr_wdata,
  input wire [7:0] tmr_rdata,
  // Interrupt
  output wire fifo_irq
);
  // Converter states, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  // Registers
  reg [7:0] cmd1_q;
  reg [7:0] cmd2_q;
  reg overflow_q;
  reg overrun_q;
  reg [1:0] state_q;
  reg [2:0] scan_ch_q;
  reg cnt_out_q;
  reg ext_q;
  reg [`ADCSEQ_FIFO_AW:0] count_q;
  reg [`ADCSEQ_FIFO_AW-1:0] wptr_q;
  reg [`ADCSEQ_FIFO_AW-1:0] rptr_q;
  reg [`ADCSEQ_REF_HALF_W-1:0] ref_div_q;

  // Decoded fields
  wire [2:0] channel_select;
  wire scan_on_n;
  wire fifo_irq_enable;
  wire acquisition_off;
  wire result_ready_flag;
  wire combined_error_flag;
  wire fifo_full;
  assign channel_select = cmd1_q[`ADCSEQ_CMD1_CH_MSB:`ADCSEQ_CMD1_CH_LSB];
  assign scan_on_n = cmd1_q[`ADCSEQ_CMD1_SCAN_N];
  assign fifo_irq_enable = cmd1_q[`ADCSEQ_CMD1_IRQEN];
  assign acquisition_off = cmd2_q[`ADCSEQ_CMD2_ACQOFF];
  assign result_ready_flag = (count_q != {(`ADCSEQ_FIFO_AW+1){1'b0}});
  assign fifo_full = (count_q == `ADCSEQ_FIFO_DEPTH);
  assign combined_error_flag = overflow_q | overrun_q; // [R1]

  // Interrupt tracks ready; drops when the FIFO drains or the interrupt enable is cleared
  assign fifo_irq = fifo_irq_enable & result_ready_flag; // [R10] [R11]

  // APB access strobes; zero wait states
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire tmr_hit;
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign tmr_hit = (paddr >= `ADCSEQ_TMR_BASE_OFF) && (paddr <= `ADCSEQ_TMR_LAST_OFF);

  // Trigger edge detection on synchronous inputs
  wire cnt_rise;
  wire ext_rise;
  wire trigger;
  wire cnt_q_rise_hold;
  assign cnt_q_rise_hold = cnt_out_q;
  assign cnt_rise = sample_counter_output & ~cnt_q_rise_hold;
  // Low-to-high on the active-low pin, gated by a high counter output
  assign ext_rise = external_convert_n & ~ext_q & sample_counter_output; // [R17]
  // Both sources blocked while acquisition is off; same path for scan
  assign trigger = ~acquisition_off & (cnt_rise | ext_rise); // [R16] [R18] [R9]

  // Pop happens on the high-byte read
  wire pop;
  wire push;
  assign pop = rd_acc & (paddr == `ADCSEQ_FIFO_HI_OFF) & result_ready_flag; // [R19] [R20]
  // A result that finds the FIFO full is dropped unless a pop frees room
  assign push = conv_done & (state_q == ST_BUSY) & (~fifo_full | pop); // [R20]
  wire clear_wr;
  assign clear_wr = wr_acc & (paddr == `ADCSEQ_CLEAR_OFF);

  // Next scan channel: count down, wrap to the selected channel
  wire [2:0] next_ch;
  assign next_ch = (scan_ch_q == 3'h0) ? channel_select : scan_ch_q - 3'h1; // [R7]

  // Memory for results
  wire [`ADCSEQ_DW-1:0] mem_rdata;
  wire [`ADCSEQ_FIFO_AW-1:0] rd_addr_next;
  assign rd_addr_next = pop ? rptr_q + 1'b1 : rptr_q;
  adcseq_fifo_mem u_mem (
    .pclk(pclk),
    .wr_en(push),
    .wr_addr(wptr_q),
    .wr_data(conv_result),
    .rd_addr(rd_addr_next),
    .rd_data(mem_rdata)
  );

  // Command registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd1_q <= `ADCSEQ_CMD1_RST;
      cmd2_q <= `ADCSEQ_CMD2_RST;
    end else begin
      if (wr_acc && paddr == `ADCSEQ_CMD1_OFF) begin
        cmd1_q <= pwdata[7:0];
      end
      if (wr_acc && paddr == `ADCSEQ_CMD2_OFF) begin
        cmd2_q <= pwdata[7:0];
      end
    end
  end

  // Error flags; a new event wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (conv_done && state_q == ST_BUSY && fifo_full && !pop) begin
        overflow_q <= 1'b1; // [R2]
      end else if (clear_wr) begin
        overflow_q <= 1'b0; // [R4]
      end
      if (trigger && state_q == ST_BUSY && !conv_done) begin
        overrun_q <= 1'b1; // [R3]
      end else if (clear_wr) begin
        overrun_q <= 1'b0; // [R4]
      end
    end
  end

  // Edge history for trigger inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_out_q <= 1'b1;
      // Idle level of the pin, so no false edge follows reset
      ext_q <= 1'b1;
    end else begin
      cnt_out_q <= sample_counter_output;
      ext_q <= external_convert_n;
    end
  end

  // Conversion sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      conv_start <= 1'b0;
      conv_channel <= 3'h0;
      scan_ch_q <= 3'h0;
    end else begin
      conv_start <= 1'b0;
      // A single-channel write reloads the scan start point
      if (scan_on_n) begin
        scan_ch_q <= channel_select;
      end
      case (state_q)
        ST_IDLE: begin
          if (trigger) begin
            conv_start <= 1'b1;
            state_q <= ST_BUSY;
            if (scan_on_n) begin
              conv_channel <= channel_select; // [R6]
            end else begin
              conv_channel <= scan_ch_q; // [R6] [R7]
              scan_ch_q <= next_ch; // [R7]
            end
          end
        end
        ST_BUSY: begin
          // Triggers arriving now are skipped and counted as overrun, except in the conv_done cycle
          if (conv_done) begin
            state_q <= ST_IDLE; // [R3]
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // FIFO pointers and fill level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= {`ADCSEQ_FIFO_AW{1'b0}};
      rptr_q <= {`ADCSEQ_FIFO_AW{1'b0}};
      count_q <= {(`ADCSEQ_FIFO_AW+1){1'b0}};
    end else if (clear_wr) begin
      // Clear write also empties the FIFO
      wptr_q <= {`ADCSEQ_FIFO_AW{1'b0}};
      rptr_q <= {`ADCSEQ_FIFO_AW{1'b0}};
      count_q <= {(`ADCSEQ_FIFO_AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Fixed 1 MHz reference for counter 0 and the connector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_q <= {`ADCSEQ_REF_HALF_W{1'b0}};
      ref_clk_1mhz <= 1'b0;
    end else if (ref_div_q == `ADCSEQ_REF_HALF - 1) begin
      ref_div_q <= {`ADCSEQ_REF_HALF_W{1'b0}};
      ref_clk_1mhz <= ~ref_clk_1mhz; // [R12] [R13]
    end else begin
      ref_div_q <= ref_div_q + 1'b1;
    end
  end

  // Timer byte port: one byte per APB access, counters untouched here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_cs <= 1'b0;
      tmr_wr <= 1'b0;
      tmr_addr <= 2'h0;
      tmr_wdata <= 8'h00;
    end else begin
      tmr_cs <= psel & ~penable & tmr_hit; // [R15] [R14]
      tmr_wr <= psel & ~penable & tmr_hit & pwrite;
      tmr_addr <= paddr[3:2];
      tmr_wdata <= pwdata[7:0]; // [R15]
    end
  end

  // Read mux, combinational into a registered data path is not needed
  always @* begin
    prdata = 32'h0;
    if (rd_acc) begin
      case (paddr)
        `ADCSEQ_CMD1_OFF: prdata = {24'h0, cmd1_q};
        `ADCSEQ_CMD2_OFF: prdata = {24'h0, cmd2_q};
        `ADCSEQ_STAT1_OFF: prdata = {28'h0, fifo_irq, state_q == ST_BUSY,
          combined_error_flag, result_ready_flag}; // [R19] [R1]
        `ADCSEQ_STAT2_OFF: prdata = {30'h0, overrun_q, overflow_q};
        `ADCSEQ_FIFO_LO_OFF: prdata = {24'h0, mem_rdata[7:0]}; // [R19]
        `ADCSEQ_FIFO_HI_OFF: prdata = {28'h0, mem_rdata[11:8]}; // [R19]
        default: begin
          // Timer bytes are taken straight from the timer port
          if (tmr_hit) begin
            prdata = {24'h0, tmr_rdata};
          end
        end
      endcase
    end
  end
endmodule // adcseq_top

// *** sim/adcseq_checker.sv ***
`timescale 1ns/1ns
// Port-level checks on the acquisition sequencer
module adcseq_checker (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB request
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Converter, timer and interrupt
  input wire sample_counter_output,
  input wire conv_start,
  input wire [2:0] conv_channel,
  input wire conv_done,
  input wire ref_clk_1mhz,
  input wire tmr_cs,
  input wire tmr_wr,
  input wire [1:0] tmr_addr,
  input wire [7:0] tmr_wdata,
  input wire fifo_irq
);
  wire wr = psel && penable && pwrite; // Write taken
  reg [4:0] cmd_q; // Command 1 shadow
  reg off_q; // Acquisition off shadow
  reg busy_q; // Conversion outstanding
  reg rp_q; // Reference last cycle
  wire tg = ref_clk_1mhz != rp_q; // Reference edge seen
  reg seen_q; // First edge passed; the first half period is not checked
  reg [6:0] rc_q; // Cycles since reference edge
  // Shadows follow the bus and the handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 5'h08;
      off_q <= 1'b1;
      busy_q <= 1'b0;
      rp_q <= 1'b0;
      seen_q <= 1'b0;
      rc_q <= 7'h0;
    end else begin
      if (wr && paddr == 12'h000) cmd_q <= pwdata[4:0];
      if (wr && paddr == 12'h004) off_q <= pwdata[1];
      busy_q <= conv_start | (busy_q & ~conv_done);
      rp_q <= ref_clk_1mhz;
      seen_q <= seen_q | tg;
      rc_q <= tg ? 7'h0 : rc_q + 7'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ref_period_a: assert property (tg && seen_q |-> rc_q == 7'd61)
    else $error("reference half period wrong");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start not one cycle");
  no_start_busy_a: assert property (conv_start |-> !busy_q)
    else $error("start while busy");
  acq_block_a: assert property (off_q && $past(off_q) && $past(off_q, 2) |-> !conv_start)
    else $error("start while acquisition off");
  ext_gate_a: assert property (!sample_counter_output && !$past(sample_counter_output)
    && !$past(sample_counter_output, 2) |-> !conv_start)
    else $error("start with counter output low");
  single_ch_a: assert property (conv_start && cmd_q[3] |-> conv_channel == cmd_q[2:0])
    else $error("single channel wrong");
  irq_en_a: assert property (fifo_irq |-> cmd_q[4])
    else $error("interrupt while disabled");
  tmr_byte_a: assert property (psel && !penable && paddr[11:4] == 8'h02 |=> tmr_cs
    && tmr_addr == $past(paddr[3:2]) && tmr_wr == $past(pwrite))
    else $error("timer access wrong");
  tmr_data_a: assert property (psel && !penable && paddr[11:4] == 8'h02 |=> tmr_wdata == $past(pwdata[7:0]))
    else $error("timer byte wrong");
  cover property (conv_start && !cmd_q[3]);
  cover property (fifo_irq);
  cover property (tmr_cs && tmr_wr);
endmodule // adcseq_checker
bind adcseq_top adcseq_checker adcseq_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .sample_counter_output, .conv_start, .conv_channel, .conv_done,
  .ref_clk_1mhz, .tmr_cs, .tmr_wr, .tmr_addr, .tmr_wdata, .fifo_irq);

// *** sim/adcseq_conv_model.sv ***
`timescale 1ns/1ns
// Converter stand-in, prompt or slow
module adcseq_conv_model (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Handshake
  input logic conv_start,
  input logic [2:0] conv_channel,
  input logic slow,
  output logic conv_done,
  output logic [11:0] conv_result
);
  int cnt; // Cycles left
  logic [2:0] ch_q; // Channel in flight
  logic [8:0] seq_q; // Result tag
  // Result carries channel and tag; data toggles outside the pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ch_q <= 3'h0;
      seq_q <= 9'h0;
      conv_done <= 1'b0;
      conv_result <= 12'h0;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        cnt <= slow ? 60 : 4;
        ch_q <= conv_channel;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_done <= 1'b1;
        conv_result <= {ch_q, seq_q};
        seq_q <= seq_q + 9'h1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // adcseq_conv_model

// *** sim/adcseq_top_tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the sequencer
module adcseq_top_tb;
  typedef struct {logic [7:0] cmd; logic [2:0] ch;} adcseq_row_t;
  adcseq_row_t rows [4] = '{'{8'h08, 3'd0}, '{8'h0d, 3'd5}, '{8'h0f, 3'd7}, '{8'h1a, 3'd2}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic sample_counter_output = 0, external_convert_n = 1;
  logic [11:0] paddr = 0, conv_result;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, conv_start, conv_done, ref_clk_1mhz, tmr_cs, tmr_wr, fifo_irq;
  logic [2:0] conv_channel;
  logic [1:0] tmr_addr;
  logic [7:0] tmr_wdata;
  int n_errors = 0, comparisons = 0;
  logic [2:0] chq[$]; // Started channels
  logic [11:0] exq[$]; // Finished results, oldest first
  always #4 pclk = ~pclk;
  adcseq_top adcseq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample_counter_output, .external_convert_n, .conv_start,
    .conv_channel, .conv_done, .conv_result, .ref_clk_1mhz, .tmr_cs, .tmr_wr, .tmr_addr,
    .tmr_wdata, .tmr_rdata(8'h5a), .fifo_irq);
  adcseq_conv_model adcseq_conv_model_i (.pclk, .presetn, .conv_start, .conv_channel, .slow,
    .conv_done, .conv_result);
  // Log starts and results
  always @(posedge pclk) begin
    if (conv_start) chq.push_back(conv_channel);
    if (conv_done) exq.push_back(conv_result);
  end
  task chk(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask
  task wrap_up;
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer, bounded wait for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    if (pready !== 1'b1) begin
      n_errors++;
      wrap_up;
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Bounded wait for n results
  task wres(input int n);
    for (int k = 0; k < 200 && exq.size() < n; k++) @(posedge pclk);
    if (exq.size() < n) begin
      n_errors++;
      wrap_up;
    end
  endtask
  // Counter output pulse
  task trig;
    sample_counter_output <= 1;
    repeat (3) @(posedge pclk);
    sample_counter_output <= 0;
    @(posedge pclk);
  endtask
  // Low byte then high byte; high read pops
  task pop;
    logic [11:0] e;
    e = exq.pop_front();
    apb(0, 12'h010, 0);
    chk(r[7:0], e[7:0]);
    apb(0, 12'h014, 0);
    chk(r[3:0], e[11:8]);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h008, 0);
    chk(r[3:0], 4'h0);
    apb(0, 12'h040, 0);
    chk(r, 0);
    trig;
    repeat (20) @(posedge pclk);
    chk(chq.size(), 0);
    apb(1, 12'h004, 0);
    foreach (rows[i]) begin
      apb(1, 12'h000, rows[i].cmd);
      trig;
      wres(1);
      chk(chq.pop_front(), rows[i].ch);
      apb(0, 12'h008, 0);
      chk(r[0], 1);
      chk(fifo_irq, rows[i].cmd[4]);
      pop;
      chk(fifo_irq, 0);
    end
    apb(1, 12'h000, 8'h1b);
    apb(1, 12'h000, 8'h13);
    for (int i = 0; i < 8; i++) begin
      trig;
      wres(i + 1);
    end
    for (int i = 0; i < 8; i++) chk(chq.pop_front(), 3 - i % 4);
    chk(fifo_irq, 1);
    repeat (8) pop;
    chk(fifo_irq, 0);
    apb(1, 12'h000, 8'h0e);
    sample_counter_output <= 1;
    wres(1);
    external_convert_n <= 0;
    @(posedge pclk);
    external_convert_n <= 1;
    wres(2);
    sample_counter_output <= 0;
    external_convert_n <= 0;
    @(posedge pclk);
    external_convert_n <= 1;
    repeat (20) @(posedge pclk);
    chk(exq.size(), 2);
    repeat (2) pop;
    for (int i = 0; i < 17; i++) begin
      trig;
      wres(i + 1);
    end
    void'(exq.pop_back());
    apb(0, 12'h00c, 0);
    chk(r[1:0], 2'b01);
    apb(0, 12'h008, 0);
    chk(r[1], 1);
    repeat (16) pop;
    apb(1, 12'h018, 0);
    apb(0, 12'h00c, 0);
    chk(r[1:0], 0);
    slow <= 1;
    trig;
    trig;
    wres(1);
    apb(0, 12'h00c, 0);
    chk(r[1:0], 2'b10);
    apb(0, 12'h008, 0);
    chk(r[1], 1);
    apb(1, 12'h018, 0);
    apb(0, 12'h008, 0);
    chk(r[1:0], 0);
    apb(1, 12'h024, 8'h34);
    apb(0, 12'h02c, 0);
    chk(r[7:0], 8'h5a);
    wrap_up;
  end
endmodule // adcseq_top_tb
